// ---- rtl/rdr_pkg.sv ----
// How it works
// RL1 - Data RAM is 1024 bytes in eight pages of 128 bytes.
// RL2 - Selected page appears in the processor window 0x6000-0x607F.
// RL3 - Receive page aliased at 0x6080, transmit page at 0x6100, always.
// RL4 - Pages: 0 parameters, 1-3 ack payload, 4 free, 5 engine, 6 rx, 7 tx.
// RL5 - Each FIFO keeps write, read, packet-start write and packet-start read indexes.
// RL6 - Data port write pushes tx, read pops rx; per-FIFO ports also exist.
// RL7 - Deallocate, retry, discard and commit copy one index onto another.
// RL8 - Auto-commit commits every written byte; auto-deallocate deallocates every read.
// RL9 - Reset state: tx auto-commit and rx auto-deallocate on, others off.
// RL10 - Fill level counts packet-start read to write; 0 empty, 128 full.
// RL11 - Available bit set while bytes lie between read and packet-start write.
// RL12 - Write to full FIFO is dropped and sets its overflow error flag.
// RL13 - Read with nothing available returns zero and sets underflow flag.
// RL14 - Above-threshold bit is 1 while fill level >= programmed threshold.
// RL15 - Write raising above-threshold from 0 to 1 sets upward-crossing flag.
// RL16 - Commands 0x80-0xFF go to FIFOs; unknown ignored; lower go to engine.
// RL17 - Rx commands 0x81 reset, 0x82 dealloc, 0x83 retry, 0x84 discard, 0x85 commit.
// RL18 - Tx commands 0x91 to 0x95 do the same on the transmit indexes.
// RL19 - Commands 0xF1 to 0xF5 act on both FIFOs at once.
// RL20 - Software index write always moves forward; same value means 128 places.
// RL21 - Software keeps circular index order and never lets one pass the next.
// RL22 - Engine owns rx write side and tx read side; MCU owns the rest.
// RL23 - Read dropping above-threshold from 1 to 0 sets downward-crossing flag.
// RL24 - A wrap bit per index tells an empty FIFO from a full one.
package rdr_pkg;
  localparam int PAGE_BYTES = 128;
  localparam int RAM_BYTES = 1024;
  localparam int RAM_AW = 10;
  localparam int IDX_W = 7;
  localparam int OP_W = 5;
  localparam int OP_RESET = 0;
  localparam int OP_DEALLOC = 1;
  localparam int OP_RETRY = 2;
  localparam int OP_DISCARD = 3;
  localparam int OP_COMMIT = 4;
  localparam logic [2:0] PG_PARAM = 3'h0;
  localparam logic [2:0] PG_FREE = 3'h4;
  localparam logic [2:0] PG_LLE = 3'h5;
  localparam logic [2:0] PG_RX = 3'h6; // see RL4
  localparam logic [2:0] PG_TX = 3'h7; // see RL4
  localparam logic [15:0] WIN_BASE = 16'h6000;
  localparam logic [15:0] RXAL_BASE = 16'h6080;
  localparam logic [15:0] TXAL_BASE = 16'h6100;
  localparam logic [7:0] SFR_DATA_PORT = 8'hD9;
  localparam logic [15:0] REG_PAGE_SEL = 16'h6180;
  localparam logic [15:0] REG_FIFO_CFG = 16'h6181;
  localparam logic [15:0] REG_STATUS = 16'h6182;
  localparam logic [15:0] REG_CROSS = 16'h6183;
  localparam logic [15:0] REG_ERR = 16'h6184;
  localparam logic [15:0] REG_RX_LEN = 16'h6185;
  localparam logic [15:0] REG_TX_LEN = 16'h6186;
  localparam logic [15:0] REG_RX_THR = 16'h6187;
  localparam logic [15:0] REG_TX_THR = 16'h6188;
  localparam logic [15:0] REG_RX_POP = 16'h6189;
  localparam logic [15:0] REG_RX_PUSH = 16'h618A;
  localparam logic [15:0] REG_TX_POP = 16'h618B;
  localparam logic [15:0] REG_TX_PUSH = 16'h618C;
  localparam logic [15:0] REG_RX_PTR = 16'h6190;
  localparam logic [15:0] REG_TX_PTR = 16'h6194;
  localparam logic [15:0] REG_CMD = 16'h6198;
  localparam logic [7:0] FIFO_CFG_RST = 8'h06; // see RL9
  localparam int CFG_RX_AC = 0;
  localparam int CFG_RX_AD = 1;
  localparam int CFG_TX_AC = 2;
  localparam int CFG_TX_AD = 3;
  localparam logic [7:0] THR_RST = 8'h00;
  localparam logic [7:0] CMD_FIFO_MIN = 8'h80;
  localparam logic [3:0] CMD_GRP_RX = 4'h8;
  localparam logic [3:0] CMD_GRP_TX = 4'h9;
  localparam logic [3:0] CMD_GRP_BOTH = 4'hF;
  localparam logic [3:0] CMD_RESET = 4'h1;
  localparam logic [3:0] CMD_COMMIT = 4'h5;

  // One-hot FIFO operations for a command aimed at group grp
  function automatic logic [OP_W-1:0] fifo_ops(input logic v, input logic [7:0] code,
                                               input logic [3:0] grp);
    logic ok;
    ok = v && (code[7:4] == grp || code[7:4] == CMD_GRP_BOTH); // see RL19
    fifo_ops = '0;
    if (ok && code[3:0] >= CMD_RESET && code[3:0] <= CMD_COMMIT) begin // see RL16
      fifo_ops = OP_W'(1) << (code[3:0] - CMD_RESET); // see RL17 see RL18
    end
  endfunction
endpackage

// ---- rtl/rdr_fifo_ptrs.sv ----
`timescale 1ns/100ps
module rdr_fifo_ptrs
  import rdr_pkg::*;
#(
  parameter int DEPTH = PAGE_BYTES
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_push,
  input wire logic i_pop,
  input wire logic i_auto_commit,
  input wire logic i_auto_dealloc,
  input wire logic [OP_W-1:0] i_op,
  input wire logic i_ptr_wr,
  input wire logic [1:0] i_ptr_sel,
  input wire logic [$clog2(DEPTH)-1:0] i_ptr_val,
  input wire logic [7:0] i_thr,
  output logic [$clog2(DEPTH)-1:0] o_wp,
  output logic [$clog2(DEPTH)-1:0] o_rp,
  output logic [$clog2(DEPTH)-1:0] o_swp,
  output logic [$clog2(DEPTH)-1:0] o_srp,
  output logic [7:0] o_len,
  output logic o_avail,
  output logic o_above,
  output logic o_push_ok,
  output logic o_pop_ok,
  output logic o_over,
  output logic o_under,
  output logic o_cross_up,
  output logic o_cross_dn
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] FULL = PW'(DEPTH);

  if (DEPTH != (1 << AW) || PW > 8 || DEPTH < 2) begin : g_chk
    $error("DEPTH must be a power of two from 2 to 128");
  end

  // Extra top bit is the wrap state that separates empty from full
  logic [PW-1:0] wp_ff; // see RL24
  logic [PW-1:0] rp_ff;
  logic [PW-1:0] swp_ff;
  logic [PW-1:0] srp_ff;

  // A write always moves forward: equal value means a full lap
  function automatic logic [PW-1:0] advance(input logic [PW-1:0] cur,
                                            input logic [AW-1:0] val);
    logic [AW-1:0] step;
    step = val - cur[AW-1:0];
    advance = cur + {step == '0, step}; // see RL20
  endfunction

  wire [PW-1:0] len = wp_ff - srp_ff; // see RL10
  wire [PW-1:0] avl = swp_ff - rp_ff;
  assign o_push_ok = i_push && len != FULL; // see RL12
  assign o_pop_ok = i_pop && avl != '0; // see RL13
  assign o_over = i_push && !o_push_ok;
  assign o_under = i_pop && !o_pop_ok;

  wire [PW-1:0] wp_p = o_push_ok ? wp_ff + PW'(1) : wp_ff; // see RL5
  wire [PW-1:0] rp_p = o_pop_ok ? rp_ff + PW'(1) : rp_ff;
  wire [PW-1:0] swp_p = (o_push_ok && i_auto_commit) ? wp_p : swp_ff; // see RL8
  wire [PW-1:0] srp_p = (o_pop_ok && i_auto_dealloc) ? rp_p : srp_ff; // see RL8

  wire [PW-1:0] srp_c = i_op[OP_DEALLOC] ? rp_p : srp_p; // see RL7
  wire [PW-1:0] rp_c = i_op[OP_RETRY] ? srp_p : rp_p; // see RL7
  wire [PW-1:0] wp_c = i_op[OP_DISCARD] ? swp_p : wp_p; // see RL7
  wire [PW-1:0] swp_c = i_op[OP_COMMIT] ? wp_p : swp_p; // see RL7

  wire clr = i_op[OP_RESET];
  wire wr_wp = i_ptr_wr && i_ptr_sel == 2'h0;
  wire wr_rp = i_ptr_wr && i_ptr_sel == 2'h1;
  wire wr_swp = i_ptr_wr && i_ptr_sel == 2'h2;
  wire wr_srp = i_ptr_wr && i_ptr_sel == 2'h3;
  wire [PW-1:0] nxt_wp = clr ? '0 : wr_wp ? advance(wp_ff, i_ptr_val) : wp_c;
  wire [PW-1:0] nxt_rp = clr ? '0 : wr_rp ? advance(rp_ff, i_ptr_val) : rp_c;
  wire [PW-1:0] nxt_swp = clr ? '0 : wr_swp ? advance(swp_ff, i_ptr_val) : swp_c;
  wire [PW-1:0] nxt_srp = clr ? '0 : wr_srp ? advance(srp_ff, i_ptr_val) : srp_c;

  wire [PW-1:0] nxt_len = nxt_wp - nxt_srp;
  wire nxt_above = 8'(nxt_len) >= i_thr;
  assign o_len = 8'(len);
  assign o_above = o_len >= i_thr; // see RL14
  assign o_avail = avl != '0; // see RL11
  assign o_cross_up = o_push_ok && !o_above && nxt_above; // see RL15
  assign o_cross_dn = o_pop_ok && o_above && !nxt_above; // see RL23
  assign o_wp = wp_ff[AW-1:0];
  assign o_rp = rp_ff[AW-1:0];
  assign o_swp = swp_ff[AW-1:0];
  assign o_srp = srp_ff[AW-1:0];

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      wp_ff <= '0;
      rp_ff <= '0;
      swp_ff <= '0;
      srp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      swp_ff <= nxt_swp;
      srp_ff <= nxt_srp;
    end
  end
endmodule

// ---- rtl/rdr_radio_ram.sv ----
`timescale 1ns/100ps
module rdr_radio_ram
  import rdr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_xaddr,
  input wire logic i_xwr,
  input wire logic i_xrd,
  input wire logic [7:0] i_xwdata,
  output logic [7:0] o_xrdata,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic i_lle_rx_push,
  input wire logic [7:0] i_lle_rx_data,
  input wire logic i_lle_tx_pop,
  output logic [7:0] o_lle_tx_data,
  input wire logic i_lle_cmd_valid,
  input wire logic [7:0] i_lle_cmd_code,
  output logic o_lle_cmd_valid,
  output logic [7:0] o_lle_cmd_code,
  output logic o_radio_error_irq
);

  logic [2:0] page_ff;
  logic [7:0] cfg_ff;
  logic [7:0] rx_thr_ff;
  logic [7:0] tx_thr_ff;
  logic [3:0] err_ff;
  logic [3:0] cross_ff;
  logic err_irq_ff;
  logic [7:0] xrdata_ff;
  logic [7:0] sfr_rdata_ff;
  logic [7:0] lle_tx_data_ff;
  logic lle_cmd_valid_ff;
  logic [7:0] lle_cmd_code_ff;

  // Whole radio RAM, all eight pages
  logic [7:0] ram_mem [RAM_BYTES]; // see RL1

  // Index picker shared by both FIFO pointer read paths
  function automatic logic [IDX_W-1:0] ptr_pick(input logic [1:0] sel,
                                                input logic [IDX_W-1:0] wp,
                                                input logic [IDX_W-1:0] rp,
                                                input logic [IDX_W-1:0] packet_start_write_index,
                                                input logic [IDX_W-1:0] packet_start_read_index);
    case (sel)
      2'h0: ptr_pick = wp;
      2'h1: ptr_pick = rp;
      2'h2: ptr_pick = packet_start_write_index;
      default: ptr_pick = packet_start_read_index;
    endcase
  endfunction

  // Processor window decode
  wire win_hit = i_xaddr[15:IDX_W] == WIN_BASE[15:IDX_W]; // see RL2
  wire rxal_hit = i_xaddr[15:IDX_W] == RXAL_BASE[15:IDX_W]; // see RL3
  wire txal_hit = i_xaddr[15:IDX_W] == TXAL_BASE[15:IDX_W]; // see RL3
  wire ram_hit = win_hit || rxal_hit || txal_hit;
  wire [2:0] ram_page = rxal_hit ? PG_RX : txal_hit ? PG_TX : page_ff; // see RL2
  wire [RAM_AW-1:0] mcu_ram_addr = {ram_page, i_xaddr[IDX_W-1:0]};

  // Register strobes
  wire wr_page = i_xwr && i_xaddr == REG_PAGE_SEL;
  wire wr_cfg = i_xwr && i_xaddr == REG_FIFO_CFG;
  wire wr_cross = i_xwr && i_xaddr == REG_CROSS;
  wire wr_err = i_xwr && i_xaddr == REG_ERR;
  wire wr_rx_thr = i_xwr && i_xaddr == REG_RX_THR;
  wire wr_tx_thr = i_xwr && i_xaddr == REG_TX_THR;
  wire wr_cmd = i_xwr && i_xaddr == REG_CMD;
  wire wr_rx_ptr = i_xwr && i_xaddr[15:2] == REG_RX_PTR[15:2];
  wire wr_tx_ptr = i_xwr && i_xaddr[15:2] == REG_TX_PTR[15:2];
  wire rd_rx_pop = i_xrd && i_xaddr == REG_RX_POP;
  wire rd_tx_pop = i_xrd && i_xaddr == REG_TX_POP;

  // Shared data port plus the per-FIFO ports
  wire sfr_push = i_sfr_wr && i_sfr_addr == SFR_DATA_PORT; // see RL6
  wire sfr_pop = i_sfr_rd && i_sfr_addr == SFR_DATA_PORT; // see RL6
  wire tx_push = sfr_push || (i_xwr && i_xaddr == REG_TX_PUSH); // see RL6
  wire [7:0] tx_push_data = sfr_push ? i_sfr_wdata : i_xwdata;
  wire rx_pop = sfr_pop || rd_rx_pop; // see RL6

  // Engine takes the receive write side and transmit read side first
  wire mcu_rx_push = i_xwr && i_xaddr == REG_RX_PUSH && !i_lle_rx_push; // see RL22
  wire mcu_tx_pop = rd_tx_pop && !i_lle_tx_pop; // see RL22
  wire rx_push = i_lle_rx_push || mcu_rx_push;
  wire [7:0] rx_push_data = i_lle_rx_push ? i_lle_rx_data : i_xwdata;
  wire tx_pop = i_lle_tx_pop || mcu_tx_pop;

  // Both command sources may hit one FIFO in a cycle; their operations merge
  wire mcu_fifo_cmd = wr_cmd && i_xwdata >= CMD_FIFO_MIN; // see RL16
  wire [OP_W-1:0] rx_op = fifo_ops(wr_cmd, i_xwdata, CMD_GRP_RX)
                        | fifo_ops(i_lle_cmd_valid, i_lle_cmd_code, CMD_GRP_RX); // see RL17
  wire [OP_W-1:0] tx_op = fifo_ops(wr_cmd, i_xwdata, CMD_GRP_TX)
                        | fifo_ops(i_lle_cmd_valid, i_lle_cmd_code, CMD_GRP_TX); // see RL18
  wire nxt_lle_cmd_valid = wr_cmd && !mcu_fifo_cmd; // see RL16

  logic [IDX_W-1:0] rx_wp;
  logic [IDX_W-1:0] rx_rp;
  logic [IDX_W-1:0] rx_swp;
  logic [IDX_W-1:0] rx_srp;
  logic [7:0] rx_len;
  logic rx_avail;
  logic rx_above;
  logic rx_push_ok;
  logic rx_pop_ok;
  logic rx_over;
  logic rx_under;
  logic rx_up;
  logic rx_dn;
  logic [IDX_W-1:0] tx_wp;
  logic [IDX_W-1:0] tx_rp;
  logic [IDX_W-1:0] tx_swp;
  logic [IDX_W-1:0] tx_srp;
  logic [7:0] tx_len;
  logic tx_avail;
  logic tx_above;
  logic tx_push_ok;
  logic tx_pop_ok;
  logic tx_over;
  logic tx_under;
  logic tx_up;
  logic tx_dn;

  rdr_fifo_ptrs #(.DEPTH(PAGE_BYTES)) u_rx (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_push(rx_push),
    .i_pop(rx_pop),
    .i_auto_commit(cfg_ff[CFG_RX_AC]),
    .i_auto_dealloc(cfg_ff[CFG_RX_AD]),
    .i_op(rx_op),
    .i_ptr_wr(wr_rx_ptr),
    .i_ptr_sel(i_xaddr[1:0]),
    .i_ptr_val(i_xwdata[IDX_W-1:0]),
    .i_thr(rx_thr_ff),
    .o_wp(rx_wp),
    .o_rp(rx_rp),
    .o_swp(rx_swp),
    .o_srp(rx_srp),
    .o_len(rx_len),
    .o_avail(rx_avail),
    .o_above(rx_above),
    .o_push_ok(rx_push_ok),
    .o_pop_ok(rx_pop_ok),
    .o_over(rx_over),
    .o_under(rx_under),
    .o_cross_up(rx_up),
    .o_cross_dn(rx_dn)
  );

  rdr_fifo_ptrs #(.DEPTH(PAGE_BYTES)) u_tx (
    .i_sys_clk(i_sys_clk),
    .i_srst(i_srst),
    .i_push(tx_push),
    .i_pop(tx_pop),
    .i_auto_commit(cfg_ff[CFG_TX_AC]),
    .i_auto_dealloc(cfg_ff[CFG_TX_AD]),
    .i_op(tx_op),
    .i_ptr_wr(wr_tx_ptr),
    .i_ptr_sel(i_xaddr[1:0]),
    .i_ptr_val(i_xwdata[IDX_W-1:0]),
    .i_thr(tx_thr_ff),
    .o_wp(tx_wp),
    .o_rp(tx_rp),
    .o_swp(tx_swp),
    .o_srp(tx_srp),
    .o_len(tx_len),
    .o_avail(tx_avail),
    .o_above(tx_above),
    .o_push_ok(tx_push_ok),
    .o_pop_ok(tx_pop_ok),
    .o_over(tx_over),
    .o_under(tx_under),
    .o_cross_up(tx_up),
    .o_cross_dn(tx_dn)
  );

  // RAM ports: A serves the processor and tx pushes, B serves rx pushes
  wire ram_a_we = tx_push_ok || (i_xwr && ram_hit);
  wire [RAM_AW-1:0] ram_a_addr = tx_push_ok ? {PG_TX, tx_wp} : mcu_ram_addr;
  wire [7:0] ram_a_data = tx_push_ok ? tx_push_data : i_xwdata;
  wire [RAM_AW-1:0] ram_b_addr = {PG_RX, rx_wp};

  // Pops on an empty FIFO hand back zero
  wire [7:0] rx_pop_data = rx_pop_ok ? ram_mem[{PG_RX, rx_rp}] : 8'h00; // see RL13
  wire [7:0] tx_pop_data = tx_pop_ok ? ram_mem[{PG_TX, tx_rp}] : 8'h00; // see RL13

  wire [7:0] status = {tx_len == 8'(PAGE_BYTES), tx_len == 8'h00, tx_above, tx_avail,
                       rx_len == 8'(PAGE_BYTES), rx_len == 8'h00, rx_above, rx_avail};
  wire [IDX_W-1:0] rx_ptr = ptr_pick(i_xaddr[1:0], rx_wp, rx_rp, rx_swp, rx_srp);
  wire [IDX_W-1:0] tx_ptr = ptr_pick(i_xaddr[1:0], tx_wp, tx_rp, tx_swp, tx_srp);

  wire [7:0] reg_rdata =
    (i_xaddr == REG_PAGE_SEL) ? {5'h00, page_ff} :
    (i_xaddr == REG_FIFO_CFG) ? cfg_ff :
    (i_xaddr == REG_STATUS) ? status :
    (i_xaddr == REG_CROSS) ? {4'h0, cross_ff} :
    (i_xaddr == REG_ERR) ? {4'h0, err_ff} :
    (i_xaddr == REG_RX_LEN) ? rx_len :
    (i_xaddr == REG_TX_LEN) ? tx_len :
    (i_xaddr == REG_RX_THR) ? rx_thr_ff :
    (i_xaddr == REG_TX_THR) ? tx_thr_ff :
    rd_rx_pop ? rx_pop_data :
    mcu_tx_pop ? tx_pop_data :
    (i_xaddr[15:2] == REG_RX_PTR[15:2]) ? {1'b0, rx_ptr} :
    (i_xaddr[15:2] == REG_TX_PTR[15:2]) ? {1'b0, tx_ptr} :
    8'h00;
  wire [7:0] nxt_xrdata = !i_xrd ? xrdata_ff : ram_hit ? ram_mem[mcu_ram_addr] : reg_rdata;
  wire [7:0] nxt_sfr_rdata = sfr_pop ? rx_pop_data : sfr_rdata_ff;
  wire [7:0] nxt_lle_tx_data = i_lle_tx_pop ? tx_pop_data : lle_tx_data_ff;

  // Sticky flags: a new event in the clearing cycle survives
  wire [3:0] err_set = {tx_under, tx_over, rx_under, rx_over}; // see RL12 see RL13
  wire [3:0] nxt_err = (wr_err ? err_ff & i_xwdata[3:0] : err_ff) | err_set;
  wire [3:0] cross_set = {tx_dn, tx_up, rx_dn, rx_up}; // see RL15 see RL23
  wire [3:0] nxt_cross = (wr_cross ? cross_ff & i_xwdata[3:0] : cross_ff) | cross_set;

  always_ff @(posedge i_sys_clk) begin
    if (ram_a_we) begin
      ram_mem[ram_a_addr] <= ram_a_data;
    end
    if (rx_push_ok) begin
      ram_mem[ram_b_addr] <= rx_push_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      page_ff <= PG_PARAM;
      cfg_ff <= FIFO_CFG_RST; // see RL9
      rx_thr_ff <= THR_RST;
      tx_thr_ff <= THR_RST;
      err_ff <= 4'h0;
      cross_ff <= 4'h0;
      err_irq_ff <= 1'b0;
    end else begin
      page_ff <= wr_page ? i_xwdata[2:0] : page_ff; // see RL2
      cfg_ff <= wr_cfg ? {4'h0, i_xwdata[3:0]} : cfg_ff;
      rx_thr_ff <= wr_rx_thr ? i_xwdata : rx_thr_ff;
      tx_thr_ff <= wr_tx_thr ? i_xwdata : tx_thr_ff;
      err_ff <= nxt_err;
      cross_ff <= nxt_cross;
      err_irq_ff <= |nxt_err; // see RL12
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      xrdata_ff <= 8'h00;
      sfr_rdata_ff <= 8'h00;
      lle_tx_data_ff <= 8'h00;
      lle_cmd_valid_ff <= 1'b0;
      lle_cmd_code_ff <= 8'h00;
    end else begin
      xrdata_ff <= nxt_xrdata;
      sfr_rdata_ff <= nxt_sfr_rdata;
      lle_tx_data_ff <= nxt_lle_tx_data;
      lle_cmd_valid_ff <= nxt_lle_cmd_valid;
      lle_cmd_code_ff <= nxt_lle_cmd_valid ? i_xwdata : lle_cmd_code_ff;
    end
  end

  assign o_xrdata = xrdata_ff;
  assign o_sfr_rdata = sfr_rdata_ff;
  assign o_lle_tx_data = lle_tx_data_ff;
  assign o_lle_cmd_valid = lle_cmd_valid_ff;
  assign o_lle_cmd_code = lle_cmd_code_ff;
  assign o_radio_error_irq = err_irq_ff;

endmodule

// ---- verification/rdr_radio_ram_properties.sv ----
`timescale 1ns/100ps
module rdr_radio_ram_props
  import rdr_pkg::*;
(
  input logic i_sys_clk,
  input logic i_srst,
  input logic [15:0] i_xaddr,
  input logic i_xwr,
  input logic i_xrd,
  input logic [7:0] i_xwdata,
  input logic [7:0] o_xrdata,
  input logic [7:0] i_sfr_addr,
  input logic i_sfr_wr,
  input logic i_sfr_rd,
  input logic [7:0] o_sfr_rdata,
  input logic i_lle_rx_push,
  input logic i_lle_tx_pop,
  input logic [7:0] o_lle_tx_data,
  input logic o_lle_cmd_valid,
  input logic [7:0] o_lle_cmd_code,
  input logic o_radio_error_irq
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  wire cmd_wr = i_xwr && i_xaddr == REG_CMD;
  wire port_rd = i_sfr_rd && i_sfr_addr == SFR_DATA_PORT;
  wire any_acc = i_xrd || i_xwr || i_sfr_rd || i_sfr_wr || i_lle_rx_push || i_lle_tx_pop;
  property p_low_cmd;
    cmd_wr && i_xwdata < CMD_FIFO_MIN |=> o_lle_cmd_valid && o_lle_cmd_code == $past(i_xwdata);
  endproperty
  a_low_cmd: assert property (p_low_cmd) else $error("low command not forwarded");
  property p_fifo_cmd;
    cmd_wr && i_xwdata >= CMD_FIFO_MIN |=> !o_lle_cmd_valid;
  endproperty
  a_fifo_cmd: assert property (p_fifo_cmd) else $error("fifo command leaked");
  property p_cmd_cause;
    o_lle_cmd_valid |-> $past(cmd_wr);
  endproperty
  a_cmd_cause: assert property (p_cmd_cause) else $error("command without write");
  property p_unmapped;
    i_xrd && (i_xaddr < WIN_BASE || i_xaddr > 16'h61F7) |=> o_xrdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_xr_hold;
    !i_xrd |=> $stable(o_xrdata);
  endproperty
  a_xr_hold: assert property (p_xr_hold) else $error("read data moved");
  property p_sr_hold;
    !port_rd |=> $stable(o_sfr_rdata);
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("data port moved");
  property p_tx_hold;
    !i_lle_tx_pop |=> $stable(o_lle_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("engine data moved");
  property p_irq_hold;
    o_radio_error_irq && !i_xwr |=> o_radio_error_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("error irq dropped");
  property p_irq_cause;
    $rose(o_radio_error_irq) |-> $past(any_acc);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("error irq without access");
  c_cmd: cover property (cmd_wr ##1 o_lle_cmd_valid);
  c_err: cover property ($rose(o_radio_error_irq));
  c_pop: cover property (i_lle_tx_pop ##1 o_lle_tx_data != 8'h00);
endmodule

bind rdr_radio_ram rdr_radio_ram_props u_props (.*);

// ---- verification/rdr_lle_model.sv ----
`timescale 1ns/100ps
module rdr_lle_model (
  input wire logic i_sys_clk,
  input wire logic [7:0] i_tx_data,
  output logic o_rx_push,
  output logic [7:0] o_rx_data,
  output logic o_tx_pop,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code
);
  initial begin
    o_rx_push = 0;
    o_rx_data = 8'h00;
    o_tx_pop = 0;
    o_cmd_valid = 0;
    o_cmd_code = 8'h00;
  end
  // Engine fills rx only; gap lets it answer slowly
  task automatic push(input logic [7:0] d, input int gap);
    repeat (gap) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    #1 o_rx_push = 1;
    o_rx_data = d;
    @(posedge i_sys_clk);
    #1 o_rx_push = 0;
    o_rx_data = ~d; // Stale byte never left on the line
  endtask
  task automatic pop(output logic [7:0] d);
    @(posedge i_sys_clk);
    #1 o_tx_pop = 1;
    @(posedge i_sys_clk);
    #1 o_tx_pop = 0;
    d = i_tx_data;
  endtask
  task automatic cmd(input logic [7:0] c);
    @(posedge i_sys_clk);
    #1 o_cmd_valid = 1;
    o_cmd_code = c;
    @(posedge i_sys_clk);
    #1 o_cmd_valid = 0;
    o_cmd_code = ~c;
  endtask
endmodule

// ---- verification/tb_rdr_radio_ram.sv ----
`timescale 1ns/100ps
module tb_rdr_radio_ram;
  import rdr_pkg::*;
  logic i_sys_clk = 0;
  logic i_srst = 1;
  logic i_xwr = 0, i_xrd = 0, i_sfr_wr = 0, i_sfr_rd = 0;
  logic [15:0] i_xaddr = '0;
  logic [7:0] i_xwdata = '0, i_sfr_addr = '0, i_sfr_wdata = '0;
  logic i_lle_rx_push, i_lle_tx_pop, i_lle_cmd_valid, o_lle_cmd_valid, o_radio_error_irq;
  logic [7:0] i_lle_rx_data, i_lle_cmd_code, o_xrdata, o_sfr_rdata, o_lle_tx_data;
  logic [7:0] o_lle_cmd_code, b;
  logic [7:0] e [4];
  int fails = 0;
  int tests_run = 0;

  rdr_radio_ram dut (.*);
  rdr_lle_model eng (
    .i_sys_clk(i_sys_clk),
    .i_tx_data(o_lle_tx_data),
    .o_rx_push(i_lle_rx_push),
    .o_rx_data(i_lle_rx_data),
    .o_tx_pop(i_lle_tx_pop),
    .o_cmd_valid(i_lle_cmd_valid),
    .o_cmd_code(i_lle_cmd_code)
  );

  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic finish_test;
    if (fails == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    tests_run++;
    if (g !== x) begin
      fails++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic xw(logic [15:0] a, logic [7:0] d);
    @(posedge i_sys_clk);
    #1 i_xaddr = a;
    i_xwdata = d;
    i_xwr = 1;
    @(posedge i_sys_clk);
    #1 i_xwr = 0;
  endtask
  task automatic xr(logic [15:0] a, logic [7:0] x, string n);
    @(posedge i_sys_clk);
    #1 i_xaddr = a;
    i_xrd = 1;
    @(posedge i_sys_clk);
    #1 i_xrd = 0;
    chk(n, x, o_xrdata);
  endtask
  task automatic sw(logic [7:0] d);
    @(posedge i_sys_clk);
    #1 i_sfr_addr = SFR_DATA_PORT;
    i_sfr_wdata = d;
    i_sfr_wr = 1;
    @(posedge i_sys_clk);
    #1 i_sfr_wr = 0;
  endtask
  task automatic sr(logic [7:0] x);
    @(posedge i_sys_clk);
    #1 i_sfr_addr = SFR_DATA_PORT;
    i_sfr_rd = 1;
    @(posedge i_sys_clk);
    #1 i_sfr_rd = 0;
    chk("data port", x, o_sfr_rdata);
  endtask
  // Order kept: write 10, packet-start write 6, read 3, packet-start read 1
  task automatic setp;
    xw(REG_CMD, 8'hF1);
    for (int f = 0; f < 2; f++) begin
      xw(REG_RX_PTR + 16'(4 * f), 8'h0A);
      xw(REG_RX_PTR + 16'(4 * f + 2), 8'h06);
      xw(REG_RX_PTR + 16'(4 * f + 1), 8'h03);
      xw(REG_RX_PTR + 16'(4 * f + 3), 8'h01);
    end
  endtask

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fails++;
    finish_test();
  end

  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1 i_srst = 0;
    xr(REG_FIFO_CFG, 8'h06, "cfg");
    xr(REG_STATUS, 8'h66, "status");
    xr(REG_ERR, 8'h00, "errors");
    xr(16'h7000, 8'h00, "unmapped");
    xw(REG_PAGE_SEL, 8'h04);
    xw(16'h6005, 8'hA5);
    xr(16'h6005, 8'hA5, "page 4");
    xw(16'h6085, 8'h3C);
    xw(16'h617F, 8'h5A);
    xw(REG_PAGE_SEL, 8'h06);
    xr(16'h6005, 8'h3C, "rx page");
    xw(REG_PAGE_SEL, 8'h07);
    xr(16'h607F, 8'h5A, "tx page");
    sw(8'h11);
    xw(REG_TX_PUSH, 8'h22);
    xr(REG_TX_LEN, 8'h02, "tx len");
    eng.pop(b);
    chk("tx byte", 8'h11, b);
    eng.pop(b);
    chk("tx byte", 8'h22, b);
    xr(REG_TX_LEN, 8'h02, "tx len");
    xr(REG_STATUS, 8'h26, "status");
    xw(REG_CMD, 8'h92);
    xr(REG_TX_LEN, 8'h00, "tx len");
    eng.pop(b);
    chk("tx under", 8'h00, b);
    xr(REG_ERR, 8'h08, "errors");
    xw(REG_ERR, 8'h00);
    eng.push(8'h41, 0);
    eng.push(8'h42, 3);
    eng.push(8'h43, 0);
    xr(REG_RX_LEN, 8'h03, "rx len");
    xr(REG_STATUS, 8'h62, "status");
    sr(8'h00);
    xr(REG_ERR, 8'h02, "errors");
    xw(REG_ERR, 8'h00);
    eng.cmd(8'h85);
    xw(REG_FIFO_CFG, 8'h04);
    sr(8'h41);
    xr(REG_RX_POP, 8'h42, "rx pop");
    xw(REG_CMD, 8'h83);
    sr(8'h41);
    xw(REG_FIFO_CFG, 8'h06);
    sr(8'h42);
    xr(REG_RX_LEN, 8'h01, "rx len");
    xw(REG_CMD, 8'hF1);
    xw(REG_RX_PTR, 8'h00);
    xr(REG_RX_LEN, 8'h80, "rx len");
    xr(REG_STATUS, 8'h6A, "status");
    eng.push(8'h77, 0);
    xr(REG_ERR, 8'h01, "errors");
    xr(REG_RX_LEN, 8'h80, "rx len");
    chk("irq", 8'h01, {7'h00, o_radio_error_irq});
    xw(REG_ERR, 8'h00);
    chk("irq", 8'h00, {7'h00, o_radio_error_irq});
    xw(REG_CMD, 8'hF1);
    xw(REG_TX_THR, 8'h02);
    xw(REG_FIFO_CFG, 8'h0E);
    xr(REG_STATUS, 8'h46, "status");
    sw(8'h01);
    sw(8'h02);
    xr(REG_CROSS, 8'h04, "cross");
    eng.pop(b);
    chk("tx byte", 8'h01, b);
    xr(REG_CROSS, 8'h0C, "cross");
    xr(REG_TX_LEN, 8'h01, "tx len");
    xw(REG_RX_THR, 8'h01);
    xw(REG_RX_PUSH, 8'h55);
    xw(REG_CMD, 8'h85);
    xr(REG_RX_POP, 8'h55, "rx pop");
    xr(REG_CROSS, 8'h0F, "cross");
    xw(REG_CROSS, 8'h00);
    xr(REG_CROSS, 8'h00, "cross");
    xr(REG_TX_POP, 8'h02, "tx pop");
    xr(REG_TX_LEN, 8'h00, "tx len");
    xw(REG_CMD, 8'h05);
    chk("lle cmd", 8'h05, o_lle_cmd_code);
    chk("lle valid", 8'h01, {7'h00, o_lle_cmd_valid});
    @(posedge i_sys_clk);
    #1 i_srst = 1;
    repeat (2) @(posedge i_sys_clk);
    #1 i_srst = 0;
    chk("lle cmd", 8'h00, o_lle_cmd_code);
    xr(REG_FIFO_CFG, 8'h06, "cfg");
    xr(REG_RX_THR, 8'h00, "rx thr");
    xr(REG_STATUS, 8'h66, "status");
    for (int g = 0; g < 3; g++) begin
      for (int op = 1; op < 7; op++) begin
        setp();
        xw(REG_CMD, {g == 2 ? CMD_GRP_BOTH : 4'(8 + g), 4'(op)});
        for (int f = 0; f < 2; f++) begin
          e = '{8'h0A, 8'h03, 8'h06, 8'h01};
          if (g == 2 || g == f) begin
            case (op)
              1: e = '{default: 8'h00};
              2: e[3] = 8'h03;
              3: e[1] = 8'h01;
              4: e[0] = 8'h06;
              5: e[2] = 8'h0A;
              default: ;
            endcase
          end
          for (int k = 0; k < 4; k++) begin
            xr(REG_RX_PTR + 16'(4 * f + k), e[k], "index");
          end
        end
      end
    end
    finish_test();
  end
endmodule
